// ==== common/pnvm_if.sv ====
interface pnvm_if;
  logic       load_select_hi;
  logic       load_select_lo;
  logic       byte_select_first;
  logic       byte_select_second;
  logic       load_clock_strobe;
  logic       page_latch_strobe;
  logic       write_n;
  logic       output_enable_n;
  logic       ready_busy;
  logic [7:0] prog_data;
  logic       prog_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] data_bus;

  // Resolved bus; undriven lines float high
  assign data_bus = dev_data_oe  ? dev_data :
                    prog_data_oe ? prog_data : 8'hFF;

  modport device (
    input  load_select_hi, load_select_lo, byte_select_first,
    input  byte_select_second, load_clock_strobe, page_latch_strobe,
    input  write_n, output_enable_n, data_bus,
    output ready_busy, dev_data, dev_data_oe
  );

  modport programmer (
    output load_select_hi, load_select_lo, byte_select_first,
    output byte_select_second, load_clock_strobe, page_latch_strobe,
    output write_n, output_enable_n, prog_data, prog_data_oe,
    input  ready_busy, data_bus
  );
endinterface : pnvm_if

// ==== common/pnvm_pkg.sv ====
package pnvm_pkg;

  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_MIN_NS      = 67;
  localparam int T_MIN_CYC     = (T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WLRL_MAX_NS = 2500;
  localparam int WLRL_CYC      = T_WLRL_MAX_NS / CLK_PERIOD_NS;
  localparam int BYTE_PROG_US  = 1500;
  localparam int FLASH_PROG_US = 12000;
  localparam int BYTE_PROG_CYC = BYTE_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int FLASH_PROG_CYC = FLASH_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int READ_WAIT_CYC = 3 * T_MIN_CYC;
  localparam int BUSY_CNT_W    = 24;

  // Load selector codes {hi, lo}
  localparam logic [1:0] LSEL_ADDR = 2'h0;
  localparam logic [1:0] LSEL_DATA = 2'h1;
  localparam logic [1:0] LSEL_CMD  = 2'h2;

  // Command bytes
  localparam logic [7:0] CMD_NOP         = 8'h00;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EE    = 8'h11;
  localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK  = 8'h20;
  localparam logic [7:0] CMD_READ_FUSE   = 8'h04;
  localparam logic [7:0] CMD_READ_SIG    = 8'h08;

  // Reserved bits that always read as unprogrammed, and the erased byte value
  localparam logic [7:0] FUSE_LOW_RSV  = 8'h30;
  localparam logic [7:0] FUSE_HIGH_RSV = 8'h10;
  localparam logic [7:0] LOCK_RSV      = 8'hC0;
  localparam logic [7:0] BYTE_ERASED   = 8'hFF;

  // Memory geometry and field positions
  localparam int PAGE_WORD_BITS = 6;
  localparam int PAGE_NUM_BITS  = 8;
  localparam int PAGE_LSB_POS   = 6;
  localparam int EE_ADDR_BITS   = 10;
  localparam int SIG_COUNT      = 3;

  // Idle pin vector: strobes low, write and output enable high, bus high
  localparam logic [15:0] PIN_IDLE = 16'h03FF;

  // Programmer operations
  typedef enum logic [2:0] {
    OP_CMD     = 3'h0,
    OP_ADDR_LO = 3'h1,
    OP_ADDR_HI = 3'h2,
    OP_DATA_LO = 3'h3,
    OP_DATA_HI = 3'h4,
    OP_LATCH   = 3'h5,
    OP_WRITE   = 3'h6,
    OP_READ    = 3'h7
  } pnvm_op_type;

endpackage : pnvm_pkg

// ==== dv/pnvm_checker.sv ====
module pnvm_checker #(
  parameter int BYTE_CYCLES  = 40,
  parameter int FLASH_CYCLES = 80
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       load_select_hi,
  input wire logic       load_select_lo,
  input wire logic       byte_select_first,
  input wire logic       load_clock_strobe,
  input wire logic       page_latch_strobe,
  input wire logic       write_n,
  input wire logic       output_enable_n,
  input wire logic       ready_busy,
  input wire logic       prog_data_oe,
  input wire logic       dev_data_oe,
  input wire logic [7:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY_MAX = 400;
  logic [23:0] busy_len;
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Busy length; cleared while ready so each period counts from zero
  always_ff @(posedge mclk) begin
    busy_len <= (rst || ready_busy) ? '0 : busy_len + 24'd1;
  end

  //////////////////////////////////////////////////////////////////////
  // Strobe must outlast the device input filter
  property p_strobe_width;
    $rose(load_clock_strobe) |-> load_clock_strobe [*7];
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("load strobe too short");
  property p_load_stable;
    load_clock_strobe |-> $stable(data_bus) && $stable(
      {load_select_hi, load_select_lo, byte_select_first});
  endproperty
  a_load_stable: assert property (p_load_stable)
    else $error("bus moved under load strobe");
  property p_latch_sel;
    page_latch_strobe |-> byte_select_first;
  endproperty
  a_latch_sel: assert property (p_latch_sel)
    else $error("latch without first select");
  // Busy only follows a write pulse, never on its own
  property p_busy_cause;
    write_n [*8] ##0 ready_busy |=> ready_busy;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without write");
  property p_busy_len;
    $rose(ready_busy) |-> busy_len inside
      {[BYTE_CYCLES-1:BYTE_CYCLES+1], [FLASH_CYCLES-1:FLASH_CYCLES+1]};
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy period wrong length");
  property p_busy_bound;
    $fell(ready_busy) |-> ##[1:BUSY_MAX] ready_busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy never ends");
  property p_oe_drop;
    output_enable_n [*8] |-> !dev_data_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("device drives without enable");
  property p_oe_need;
    $rose(dev_data_oe) |-> !output_enable_n;
  endproperty
  a_oe_need: assert property (p_oe_need)
    else $error("drive started with enable high");
  // Two drivers on the bus would corrupt both ends
  property p_no_clash;
    !(dev_data_oe && prog_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("bus driven by both ends");
  c_busy: cover property ($fell(ready_busy));
  c_read: cover property ($rose(dev_data_oe));
  c_latch: cover property ($rose(page_latch_strobe));
endmodule : pnvm_checker

// ==== dv/tb_parallel_nvm_programming_port.sv ====
module tb_parallel_nvm_programming_port
  import pnvm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BYTE_CYC  = 40;
  localparam int FLASH_CYC = 80;
  // Signature values are arbitrary
  localparam logic [7:0] SIG0 = 8'h12;
  localparam logic [7:0] SIG1 = 8'h34;
  localparam logic [7:0] SIG2 = 8'h56;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  pnvm_op_type cmd_op = OP_CMD;
  logic [7:0]  cmd_byte = 8'h00;
  logic        cmd_first = 1'b0;
  logic        cmd_second = 1'b0;
  logic [13:0] flash_rd_addr = '0;
  logic [9:0]  ee_rd_addr = '0;
  logic        op_done;
  logic        rb_q = 1'b1;
  logic [15:0] flash_rd_data;
  logic [7:0]  rd_data, ee_rd_data, fuse_low, fuse_high, lock_bits;
  int          num_errors = 0;
  int          compares = 0;
  int          busy_starts = 0;

  pnvm_if pins_if ();
  pnvm_device #(.BYTE_CYCLES(BYTE_CYC), .FLASH_CYCLES(FLASH_CYC),
    .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2))
  pnvm_device_inst (.mclk(mclk), .rst(rst), .pins(pins_if),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .ee_rd_addr(ee_rd_addr), .ee_rd_data(ee_rd_data),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .lock_bits(lock_bits));
  pnvm_programmer pnvm_programmer_inst (.mclk(mclk), .rst(rst),
    .pins(pins_if), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_byte(cmd_byte), .cmd_first(cmd_first), .cmd_second(cmd_second),
    .cmd_ready(), .op_done(op_done), .rd_valid(), .rd_data(rd_data));
  pnvm_checker #(.BYTE_CYCLES(BYTE_CYC), .FLASH_CYCLES(FLASH_CYC))
  pnvm_checker_inst (.mclk(mclk), .rst(rst),
    .load_select_hi(pins_if.load_select_hi),
    .load_select_lo(pins_if.load_select_lo),
    .byte_select_first(pins_if.byte_select_first),
    .load_clock_strobe(pins_if.load_clock_strobe),
    .page_latch_strobe(pins_if.page_latch_strobe),
    .write_n(pins_if.write_n), .output_enable_n(pins_if.output_enable_n),
    .ready_busy(pins_if.ready_busy), .prog_data_oe(pins_if.prog_data_oe),
    .dev_data_oe(pins_if.dev_data_oe), .data_bus(pins_if.data_bus));

  initial forever #5 mclk = ~mclk;
  // Count write starts, so a refused write can be told apart
  always @(posedge mclk) begin
    rb_q <= pins_if.ready_busy;
    if (rb_q && !pins_if.ready_busy) busy_starts++;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    compares++;
    if (act !== exp) begin
      $display("mismatch %0t got %h want %h", $time, act, exp);
      num_errors++;
    end
  endtask : chk
  // One programmer operation; bounded so a hang ends the run
  task automatic op(input pnvm_op_type o, input logic [7:0] b,
                    input logic f = 1'b0, input logic s = 1'b0);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_byte <= b;
    cmd_first <= f;
    cmd_second <= s;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 3000 && op_done !== 1'b1; n++) @(posedge mclk);
    if (n >= 3000) begin
      $display("mismatch %0t timeout", $time);
      num_errors++;
      final_report();
    end
  endtask : op
  task automatic rd(input logic f, input logic s, input logic [7:0] e);
    op(OP_READ, 8'h00, f, s);
    chk(rd_data, e);
  endtask : rd

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(pins_if.ready_busy, 1'b1);
    chk(pins_if.dev_data_oe, 1'b0);
    chk(lock_bits, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  // Reserved fuse bits written as programmed must stay erased
  task automatic t_fuse();
    op(OP_CMD, CMD_WRITE_FUSE);
    op(OP_DATA_LO, 8'h0A);
    op(OP_WRITE, 8'h00);
    op(OP_DATA_LO, 8'h00);
    op(OP_WRITE, 8'h00, 1'b1);
    chk(fuse_low, 8'h3A);
    chk(fuse_high, 8'h10);
    op(OP_CMD, CMD_READ_FUSE);
    rd(1'b0, 1'b0, 8'h3A);
    rd(1'b1, 1'b1, 8'h10);
    $display("test fuse done");
  endtask : t_fuse
  // Second write tries to erase bits; programmed bits must stay
  task automatic t_lock();
    op(OP_CMD, CMD_WRITE_LOCK);
    op(OP_DATA_LO, 8'hF3);
    op(OP_WRITE, 8'h00);
    op(OP_DATA_LO, 8'h3C);
    op(OP_WRITE, 8'h00);
    chk(lock_bits, 8'hF0);
    op(OP_CMD, CMD_READ_FUSE);
    rd(1'b1, 1'b0, 8'hF0);
    rd(1'b0, 1'b1, 8'hFF);
    $display("test lock done");
  endtask : t_lock
  // Command loaded once; the fourth index is out of range
  task automatic t_sig();
    logic [7:0] sig [4] = '{SIG0, SIG1, SIG2, 8'hFF};
    op(OP_CMD, CMD_READ_SIG);
    for (int i = 0; i < 4; i++) begin
      op(OP_ADDR_LO, 8'(i));
      rd(1'b0, 1'b0, sig[i]);
    end
    $display("test signature done");
  endtask : t_sig
  task automatic t_ee();
    op(OP_CMD, CMD_WRITE_EE);
    op(OP_ADDR_HI, 8'h03);
    op(OP_ADDR_LO, 8'h45);
    op(OP_DATA_LO, 8'h99);
    op(OP_WRITE, 8'h00);
    op(OP_ADDR_LO, 8'h46);
    op(OP_DATA_LO, 8'h77);
    op(OP_WRITE, 8'h00);
    ee_rd_addr <= 10'h345;
    repeat (2) @(posedge mclk);
    chk(ee_rd_data, 8'h99);
    ee_rd_addr <= 10'h346;
    repeat (2) @(posedge mclk);
    chk(ee_rd_data, 8'h77);
    $display("test eeprom done");
  endtask : t_ee
  // Full page; address low bits 7..6 pick page 16 hex with high byte 05
  task automatic t_flash();
    logic [5:0] w;
    int         starts;
    op(OP_CMD, CMD_WRITE_FLASH);
    op(OP_ADDR_HI, 8'h05);
    for (int i = 0; i < 64; i++) begin
      w = 6'(i);
      op(OP_ADDR_LO, {2'b10, w});
      op(OP_DATA_LO, {2'b00, w});
      op(OP_DATA_HI, {2'b11, ~w});
      op(OP_LATCH, 8'h00);
    end
    op(OP_WRITE, 8'h00);
    op(OP_CMD, CMD_NOP);
    for (int i = 0; i < 64; i++) begin
      w = 6'(i);
      flash_rd_addr <= {8'h16, w};
      repeat (2) @(posedge mclk);
      chk(flash_rd_data, {2'b11, ~w, 2'b00, w});
    end
    starts = busy_starts;
    // A reload alone must not re-arm the write
    op(OP_CMD, CMD_WRITE_FLASH);
    op(OP_WRITE, 8'h00);
    chk(16'(busy_starts), 16'(starts));
    $display("test flash done");
  endtask : t_flash

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_fuse();
    t_lock();
    t_sig();
    t_ee();
    t_flash();
    final_report();
  end
endmodule : tb_parallel_nvm_programming_port

// ==== hw/pnvm_device.sv ====
// Summary of operation
// - Selector 01 plus strobe loads data byte
// - First byte select chooses high data byte
// - Page latch with select high fills buffer
// - Programmer loads 64 words per page
// - Page number from address high and low
// - Selector 00, select high loads address high
// - Write pulse programs page, busy until done
// - No-operation command clears write signals
// - Command 11 hex selects EEPROM write
// - Write pulse, select low, programs one byte
// - Command and address kept across writes
// - Programmer skips FF, reloads high rarely
// - Fuse low write, reserved bits forced one
// - Fuse high write with first select high
// - Lock write, top two bits reserved
// - Lock bits only ever become programmed
// - Fuse and lock readback by byte selects
// - Signature byte readback by address low
// - Flash is 256 pages, whole page programmed
module pnvm_device
  import pnvm_pkg::*;
#(
  parameter int         BYTE_CYCLES    = BYTE_PROG_CYC,
  parameter int         FLASH_CYCLES   = FLASH_PROG_CYC,
  parameter logic [7:0] FUSE_LOW_INIT  = 8'hFF,
  parameter logic [7:0] FUSE_HIGH_INIT = 8'hFF,
  parameter logic [7:0] LOCK_INIT      = 8'hFF,
  // Signature values are arbitrary
  parameter logic [7:0] SIG_BYTE0      = 8'h5A,
  parameter logic [7:0] SIG_BYTE1      = 8'hA5,
  parameter logic [7:0] SIG_BYTE2      = 8'h3C
) (
  input  wire logic                                mclk,
  input  wire logic                                rst,
  pnvm_if.device                                   pins,
  input  wire logic [PAGE_NUM_BITS+PAGE_WORD_BITS-1:0] flash_rd_addr,
  output logic      [15:0]                         flash_rd_data,
  input  wire logic [EE_ADDR_BITS-1:0]             ee_rd_addr,
  output logic      [7:0]                          ee_rd_data,
  output logic      [7:0]                          fuse_low,
  output logic      [7:0]                          fuse_high,
  output logic      [7:0]                          lock_bits
);

  localparam int FLASH_WORDS = 1 << (PAGE_NUM_BITS + PAGE_WORD_BITS);
  localparam int PAGE_WORDS  = 1 << PAGE_WORD_BITS;
  localparam int EE_BYTES    = 1 << EE_ADDR_BITS;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and glitch filter

  logic [15:0] pin_raw;
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] sync3;
  logic [15:0] pin;
  logic [15:0] pin_q;

  assign pin_raw = {pins.load_select_hi, pins.load_select_lo,
                    pins.byte_select_first, pins.byte_select_second,
                    pins.load_clock_strobe, pins.page_latch_strobe,
                    pins.write_n, pins.output_enable_n, pins.data_bus};

  // Three stages; a bit rises only when the last two are both high, and falls as soon as either is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      pin   <= PIN_IDLE;
      pin_q <= PIN_IDLE;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= (sync2 & sync3) | (pin & ~(sync2 ^ sync3));
      pin_q <= pin;
    end
  end

  logic [1:0] load_sel;
  logic       byte_select_first;
  logic       byte_select_second;
  logic       output_enable_n;
  logic [7:0] bus_in;
  logic       clock_rise;
  logic       latch_rise;
  logic       write_fall;

  assign load_sel           = pin[15:14];
  assign byte_select_first  = pin[13];
  assign byte_select_second = pin[12];
  assign output_enable_n    = pin[8];
  assign bus_in             = pin[7:0];
  assign clock_rise         = pin[11] & ~pin_q[11];
  assign latch_rise         = pin[10] & ~pin_q[10];
  assign write_fall         = ~pin[9] & pin_q[9];

  //////////////////////////////////////////////////////////////////////////
  // Command, address and data latches

  logic [7:0] command;
  logic [7:0] addr_hi;
  logic [7:0] addr_lo;
  logic [7:0] data_hi;
  logic [7:0] data_lo;

  // Latches hold until reloaded, even across programming
  always_ff @(posedge mclk) begin
    if (rst) begin
      command <= CMD_NOP;
      addr_hi <= 8'h00;
      addr_lo <= 8'h00;
      data_hi <= BYTE_ERASED;
      data_lo <= BYTE_ERASED;
    end else if (clock_rise) begin
      case (load_sel)
        LSEL_ADDR: begin
          if (byte_select_first) begin
            addr_hi <= bus_in;
          end else begin
            addr_lo <= bus_in;
          end
        end
        LSEL_DATA: begin
          if (byte_select_first) begin
            data_hi <= bus_in;
          end else begin
            data_lo <= bus_in;
          end
        end
        LSEL_CMD: begin
          command <= bus_in;
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Page buffer

  logic [15:0] page_buf [PAGE_WORDS];
  logic        write_armed;

  // Word index is the low address; its top two bits, with address high, pick the page
  always_ff @(posedge mclk) begin
    if (latch_rise && byte_select_first) begin
      page_buf[addr_lo[PAGE_WORD_BITS-1:0]] <= {data_hi, data_lo};
    end
  end

  // A latched page arms the write; the no-operation load disarms it
  always_ff @(posedge mclk) begin
    if (rst) begin
      write_armed <= 1'b0;
    end else if (latch_rise && byte_select_first) begin
      write_armed <= 1'b1;
    end else if (clock_rise && load_sel == LSEL_CMD && bus_in == CMD_NOP) begin
      write_armed <= 1'b0;
    end
  end

  function automatic logic [PAGE_NUM_BITS-1:0] page_number(
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    page_number = {hi[PAGE_NUM_BITS-3:0], lo[7:PAGE_LSB_POS]};
  endfunction : page_number

  //////////////////////////////////////////////////////////////////////////
  // Write start decode and busy timer

  logic                  ready;
  logic [BUSY_CNT_W-1:0] busy_cnt;
  logic                  start_ok;
  logic                  flash_go;
  logic                  ee_go;
  logic                  fuse_go;
  logic                  lock_go;

  // Write pulses during busy are ignored
  assign start_ok = write_fall & ready;
  assign flash_go = start_ok && command == CMD_WRITE_FLASH && write_armed;
  assign ee_go    = start_ok && command == CMD_WRITE_EE && !byte_select_first;
  assign fuse_go  = start_ok && command == CMD_WRITE_FUSE;
  assign lock_go  = start_ok && command == CMD_WRITE_LOCK;

  // Busy length depends on page or byte write
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_cnt <= '0;
      ready    <= 1'b1;
    end else if (flash_go) begin
      busy_cnt <= BUSY_CNT_W'(FLASH_CYCLES);
      ready    <= 1'b0;
    end else if (ee_go || fuse_go || lock_go) begin
      busy_cnt <= BUSY_CNT_W'(BYTE_CYCLES);
      ready    <= 1'b0;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - BUSY_CNT_W'(1);
      if (busy_cnt == BUSY_CNT_W'(1)) begin
        ready <= 1'b1;
      end
    end
  end

  assign pins.ready_busy = ready;

  //////////////////////////////////////////////////////////////////////////
  // Flash and EEPROM arrays

  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0]  ee_mem    [EE_BYTES];

  // Whole page copied at once so later loads cannot disturb it
  always_ff @(posedge mclk) begin
    if (flash_go) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flash_mem[{page_number(addr_hi, addr_lo),
                   PAGE_WORD_BITS'(i)}] <= page_buf[i];
      end
    end
  end

  // Only the low two high-address bits reach the array
  always_ff @(posedge mclk) begin
    if (ee_go) begin
      ee_mem[{addr_hi[EE_ADDR_BITS-9:0], addr_lo}] <= data_lo;
    end
  end

  // User-side read ports, one cycle latency
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_rd_data <= 16'hFFFF;
      ee_rd_data    <= BYTE_ERASED;
    end else begin
      flash_rd_data <= flash_mem[flash_rd_addr];
      ee_rd_data    <= ee_mem[ee_rd_addr];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fuse and lock bits

  // Zero programs, one erases; reserved bits stay one
  always_ff @(posedge mclk) begin
    if (rst) begin
      fuse_low  <= FUSE_LOW_INIT | FUSE_LOW_RSV;
      fuse_high <= FUSE_HIGH_INIT | FUSE_HIGH_RSV;
    end else if (fuse_go) begin
      if (byte_select_first) begin
        fuse_high <= data_lo | FUSE_HIGH_RSV;
      end else begin
        fuse_low <= data_lo | FUSE_LOW_RSV;
      end
    end
  end

  // AND keeps programmed bits; no erase path exists here
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_bits <= LOCK_INIT | LOCK_RSV;
    end else if (lock_go) begin
      lock_bits <= lock_bits & (data_lo | LOCK_RSV);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Readback

  function automatic logic [7:0] signature_byte(input logic [7:0] idx);
    case (idx)
      8'h00:   signature_byte = SIG_BYTE0;
      8'h01:   signature_byte = SIG_BYTE1;
      8'h02:   signature_byte = SIG_BYTE2;
      default: signature_byte = BYTE_ERASED;
    endcase
  endfunction : signature_byte

  logic       read_en;
  logic [7:0] read_val;

  always_comb begin
    read_en  = 1'b0;
    read_val = BYTE_ERASED;
    if (!output_enable_n && command == CMD_READ_FUSE) begin
      read_en = 1'b1;
      case ({byte_select_second, byte_select_first})
        2'b00:   read_val = fuse_low;
        2'b11:   read_val = fuse_high;
        2'b01:   read_val = lock_bits;
        default: read_val = BYTE_ERASED;
      endcase
    end else if (!output_enable_n && command == CMD_READ_SIG &&
                 !byte_select_first) begin
      read_en  = 1'b1;
      read_val = signature_byte(addr_lo);
    end
  end

  logic [7:0] dev_data;
  logic       dev_data_oe;

  // Registered drive; released one cycle after the filtered enable rises
  always_ff @(posedge mclk) begin
    if (rst) begin
      dev_data    <= BYTE_ERASED;
      dev_data_oe <= 1'b0;
    end else begin
      dev_data    <= read_val;
      dev_data_oe <= read_en;
    end
  end

  assign pins.dev_data    = dev_data;
  assign pins.dev_data_oe = dev_data_oe;

endmodule : pnvm_device

// ==== hw/pnvm_programmer.sv ====
module pnvm_programmer
  import pnvm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  pnvm_if.programmer       pins,
  input  wire logic        cmd_valid,
  input  wire pnvm_op_type cmd_op,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_first,
  input  wire logic        cmd_second,
  output logic             cmd_ready,
  output logic             op_done,
  output logic             rd_valid,
  output logic [7:0]       rd_data
);

  localparam logic [15:0] PULSE_CYC = 16'(T_MIN_CYC);
  localparam logic [15:0] LOW_CYC   = 16'(WLRL_CYC);
  localparam logic [15:0] READ_CYC  = 16'(READ_WAIT_CYC);

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b00_0001,
    ST_SETUP   = 6'b00_0010,
    ST_PULSE   = 6'b00_0100,
    ST_HOLD    = 6'b00_1000,
    ST_WAIT_LO = 6'b01_0000,
    ST_WAIT_HI = 6'b10_0000
  } pnvm_state_type;

  //////////////////////////////////////////////////////////////////////////
  // Ready/busy and bus synchronisers

  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] sync3;
  logic [8:0] pin;

  // Filter waits for the last two stages to agree high; either one low clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= 9'h1FF;
      sync2 <= 9'h1FF;
      sync3 <= 9'h1FF;
      pin   <= 9'h1FF;
    end else begin
      sync1 <= {pins.ready_busy, pins.data_bus};
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= (sync2 & sync3) | (pin & ~(sync2 ^ sync3));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  pnvm_state_type state;
  pnvm_op_type    op;
  logic [15:0]    timer;
  logic [1:0]     sel;
  logic           bs1;
  logic           bs2;
  logic           strobe;
  logic           oe_n;
  logic [7:0]     pdata;
  logic           pdata_oe;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state     <= ST_IDLE;
      op        <= OP_CMD;
      timer     <= '0;
      sel       <= LSEL_ADDR;
      bs1       <= 1'b0;
      bs2       <= 1'b0;
      strobe    <= 1'b0;
      oe_n      <= 1'b1;
      pdata     <= 8'h00;
      pdata_oe  <= 1'b0;
      cmd_ready <= 1'b1;
      op_done   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
    end else begin
      op_done  <= 1'b0;
      rd_valid <= 1'b0;
      timer    <= timer + 16'(1);
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            op        <= cmd_op;
            cmd_ready <= 1'b0;
            timer     <= '0;
            pdata     <= cmd_byte;
            pdata_oe  <= cmd_op != OP_READ;
            state     <= ST_SETUP;
            case (cmd_op)
              OP_CMD: begin
                sel <= LSEL_CMD;
                bs1 <= 1'b0;
              end
              OP_ADDR_LO: begin
                sel <= LSEL_ADDR;
                bs1 <= 1'b0;
              end
              OP_ADDR_HI: begin
                sel <= LSEL_ADDR;
                bs1 <= 1'b1;
              end
              OP_DATA_LO: begin
                sel <= LSEL_DATA;
                bs1 <= 1'b0;
              end
              OP_DATA_HI: begin
                sel <= LSEL_DATA;
                bs1 <= 1'b1;
              end
              OP_LATCH: begin
                bs1 <= 1'b1;
              end
              OP_WRITE: begin
                bs1 <= cmd_first;
              end
              default: begin
                bs1 <= cmd_first;
                bs2 <= cmd_second;
              end
            endcase
          end
        end
        // Setup before the strobe edge
        ST_SETUP: begin
          if (timer == PULSE_CYC) begin
            timer <= '0;
            state <= ST_PULSE;
            if (op == OP_READ) begin
              oe_n <= 1'b0;
            end else begin
              strobe <= 1'b1;
            end
          end
        end
        // Strobe held, or read data allowed to settle
        ST_PULSE: begin
          if (timer == ((op == OP_READ) ? READ_CYC : PULSE_CYC)) begin
            timer  <= '0;
            strobe <= 1'b0;
            state  <= ST_HOLD;
            if (op == OP_READ) begin
              rd_data  <= pin[7:0];
              rd_valid <= 1'b1;
              oe_n     <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (timer == PULSE_CYC) begin
            timer <= '0;
            if (op == OP_WRITE) begin
              state <= ST_WAIT_LO;
            end else begin
              state     <= ST_IDLE;
              op_done   <= 1'b1;
              cmd_ready <= 1'b1;
            end
          end
        end
        // Bounded wait: an ignored write never drops busy
        ST_WAIT_LO: begin
          if (!pin[8] || timer == LOW_CYC) begin
            state <= ST_WAIT_HI;
          end
        end
        // Hold the select until ready returns, then release it
        ST_WAIT_HI: begin
          if (pin[8]) begin
            bs1       <= 1'b0;
            state     <= ST_IDLE;
            op_done   <= 1'b1;
            cmd_ready <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Strobe routed to the pin that the operation needs
  assign pins.load_clock_strobe  = strobe && op <= OP_DATA_HI;
  assign pins.page_latch_strobe  = strobe && op == OP_LATCH;
  assign pins.write_n            = !(strobe && op == OP_WRITE);
  assign pins.load_select_hi     = sel[1];
  assign pins.load_select_lo     = sel[0];
  assign pins.byte_select_first  = bs1;
  assign pins.byte_select_second = bs2;
  assign pins.output_enable_n    = oe_n;
  assign pins.prog_data          = pdata;
  assign pins.prog_data_oe       = pdata_oe;

endmodule : pnvm_programmer
